// *** common/dmem_pkg.sv ***
// Constants, address map and types shared by the data memory and table read logic.
// Assumes one core clock; the instruction sequencer drives all requests on that clock.
package dmem_pkg;

	// Widths
	localparam int DATA_W   = 8;
	localparam int PADDR_W  = 11;
	localparam int PWORD_W  = 15;
	localparam int HIGH_W   = PWORD_W - DATA_W;
	localparam int PAGE_W   = 3;
	localparam int GP_IDX_W = 7;
	localparam int GP_DEPTH = 96;

	// Data memory map
	localparam logic [7:0] ADDR_IND       = 8'h00;
	localparam logic [7:0] ADDR_PTR       = 8'h01;
	localparam logic [7:0] ADDR_ACC       = 8'h05;
	localparam logic [7:0] ADDR_TBL_LOW   = 8'h07;
	localparam logic [7:0] ADDR_TBL_HIGH  = 8'h08;
	localparam logic [7:0] ADDR_TBL_UPPER = 8'h1F;
	localparam logic [7:0] GP_BASE        = 8'h20;
	localparam logic [7:0] GP_LAST        = 8'h7F;

	// Values
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// Program memory last page base
	localparam logic [PADDR_W-1:0] LAST_PAGE_BASE = 11'h700;

	typedef enum logic [0:0] {
		TBL_IDLE  = 1'b0,
		TBL_FETCH = 1'b1
	} tbl_state_t;

	typedef enum logic [0:0] {
		SRC_ACC = 1'b0,
		SRC_ALU = 1'b1
	} wr_src_t;

	typedef enum logic [1:0] {
		BOP_NONE = 2'b00,
		BOP_SET  = 2'b01,
		BOP_CLR  = 2'b10
	} bit_op_t;

endpackage

// *** rtl/addr_resolve.sv ***
// Turns a data memory address into the location really accessed.
// Assumes the pointer value comes from the register file on the same clock.
`timescale 1ns/1ns
module addr_resolve
	import dmem_pkg::*;
(
	input  wire logic [7:0] addr_i,
	input  wire logic [7:0] ptr_i,
	output logic      [7:0] eff_o,
	output logic            null_o
);

	// The indirect port has no storage; its accesses go through the pointer
	assign eff_o  = (addr_i == ADDR_IND) ? ptr_i : addr_i;
	// Pointer aimed back at the port: reads give zero, writes are dropped
	assign null_o = (eff_o == ADDR_IND);

endmodule

// *** rtl/table_addr_gen.sv ***
// Builds the program memory address of a table read from the table pointers.
// Assumes pc_page_i holds the page bits of the instruction being executed.
`timescale 1ns/1ns
module table_addr_gen
	import dmem_pkg::*;
(
	input  wire logic               last_page_i,
	input  wire logic               upper_en_i,
	input  wire logic [PAGE_W-1:0]  pc_page_i,
	input  wire logic [PAGE_W-1:0]  upper_i,
	input  wire logic [7:0]         ptr_low_i,
	output logic      [PADDR_W-1:0] addr_o
);

	logic [PAGE_W-1:0] page;

	// Upper pointer replaces the running page only when the option is on
	assign page = upper_en_i ? upper_i : pc_page_i;

	// Low pointer is an offset from the chosen page base
	assign addr_o = last_page_i ? (LAST_PAGE_BASE + {{PAGE_W{1'b0}}, ptr_low_i})
		: {page, ptr_low_i};

endmodule

// *** rtl/data_memory_table_access.sv ***
// Data memory, accumulator, indirect port and program memory table read path.
// Assumes the sequencer issues at most one write and one read per cycle, and
// an asynchronous-read program memory answering prog_addr_o in the same cycle.
//
// Summary of operation
// - Last-page read fetches 700H plus table pointer
// - Current-page read offsets pointer from executing page
// - Low byte to target, upper bits to high-byte register
// - High-byte register ignores program writes
// - Every table read takes two cycles
// - Eight-bit memory from 00H, special registers lowest
// - Special and general areas form one contiguous range
// - Unused special locations read back 00H
// - Bit set/clear works on every writable location
// - Read-only special registers ignore program writes
// - General locations are readable and writable
// - Address 00H has no storage, indirect port
// - Port accesses go to pointer-addressed location
// - Port via pointer reads 00H, write ignored
// - Pointer is an ordinary writable register
// - Accumulator takes ALU intermediate results
// - Register to register moves go through accumulator
// - Upper pointer bits 2:0 supply page when enabled
`timescale 1ns/1ns
module data_memory_table_access
	import dmem_pkg::*;
(
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire logic               rd_en_i,
	input  wire logic [7:0]         rd_addr_i,
	output logic      [7:0]         rd_data_o,
	input  wire logic               wr_en_i,
	input  wire logic [7:0]         wr_addr_i,
	input  wire logic               wr_src_i,
	input  wire logic [1:0]         bit_op_i,
	input  wire logic [2:0]         bit_sel_i,
	input  wire logic [7:0]         alu_data_i,
	input  wire logic               acc_load_i,
	output logic      [7:0]         acc_o,
	input  wire logic               tbl_req_i,
	input  wire logic               tbl_last_page_i,
	input  wire logic [7:0]         tbl_dest_i,
	input  wire logic [PADDR_W-1:0] pc_i,
	input  wire logic               upper_en_i,
	output logic                    tbl_busy_o,
	output logic                    tbl_done_o,
	output logic      [PADDR_W-1:0] prog_addr_o,
	input  wire logic [PWORD_W-1:0] prog_data_i
);

	tbl_state_t         state_q;
	logic [7:0]         ptr_q;
	logic [7:0]         acc_q;
	logic [7:0]         tbl_low_q;
	logic [7:0]         tbl_high_q;
	logic [7:0]         tbl_upper_q;
	logic [7:0]         mem_q [GP_DEPTH];
	logic [7:0]         tdest_q;
	logic               tdest_null_q;
	logic [7:0]         rd_data_q;
	logic               done_q;
	logic [PADDR_W-1:0] paddr_q;
	logic [PADDR_W-1:0] paddr_d;
	logic [7:0]         rd_eff;
	logic               rd_null;
	logic [7:0]         wr_eff;
	logic               wr_null;
	logic [7:0]         td_eff;
	logic               td_null;
	logic               tbl_take;
	logic               seq_wr;
	logic [7:0]         seq_data;
	logic [7:0]         cur_val;
	logic [7:0]         w_addr;
	logic [7:0]         w_data;
	logic               w_do;

	// True for the general purpose window
	function automatic logic in_gp(input logic [7:0] a);
		in_gp = (a >= GP_BASE) && (a <= GP_LAST);
	endfunction

	// Read multiplexer over every location; holes read as zero
	function automatic logic [7:0] read_loc(input logic [7:0] a);
		logic [7:0] idx;
		idx = a - GP_BASE;
		case (a)
			ADDR_PTR:  read_loc = ptr_q;
			ADDR_ACC:  read_loc = acc_q;
			ADDR_TBL_LOW:   read_loc = tbl_low_q;
			ADDR_TBL_HIGH:  read_loc = tbl_high_q;
			ADDR_TBL_UPPER: read_loc = tbl_upper_q;
			default:   read_loc = in_gp(a) ? mem_q[idx[GP_IDX_W-1:0]] : ZERO_BYTE;
		endcase
	endfunction

	// Three independent resolvers: read, sequencer write, table target
	addr_resolve u_rd_res (
		.addr_i (rd_addr_i),
		.ptr_i  (ptr_q),
		.eff_o  (rd_eff),
		.null_o (rd_null)
	);

	addr_resolve u_wr_res (
		.addr_i (wr_addr_i),
		.ptr_i  (ptr_q),
		.eff_o  (wr_eff),
		.null_o (wr_null)
	);

	addr_resolve u_td_res (
		.addr_i (tbl_dest_i),
		.ptr_i  (ptr_q),
		.eff_o  (td_eff),
		.null_o (td_null)
	);

	table_addr_gen u_tag (
		.last_page_i (tbl_last_page_i),
		.upper_en_i  (upper_en_i),
		.pc_page_i   (pc_i[PADDR_W-1:DATA_W]),
		.upper_i     (tbl_upper_q[PAGE_W-1:0]),
		.ptr_low_i   (tbl_low_q),
		.addr_o      (paddr_d)
	);

	// Sequencer writes are dropped while a table read owns the write port
	assign tbl_take = tbl_req_i && (state_q == TBL_IDLE);
	assign seq_wr   = wr_en_i && (state_q == TBL_IDLE);

	// Bit ops read the target here; a process, so that RAM and register
	// updates retrigger the lookup and not only address changes
	always_comb
	begin
		cur_val = read_loc(wr_eff);
	end

	// Stored data comes from the accumulator, the ALU or a bit op on the target itself, never another location
	always_comb
	begin
		seq_data = (wr_src_i == SRC_ALU) ? alu_data_i : acc_q;
		case (bit_op_i)
			BOP_SET: seq_data = cur_val | (8'h01 << bit_sel_i);
			BOP_CLR: seq_data = cur_val & ~(8'h01 << bit_sel_i);
			default: seq_data = (wr_src_i == SRC_ALU) ? alu_data_i : acc_q;
		endcase
	end

	// Single write port: table load in its second cycle, else the sequencer
	always_comb
	begin
		if (state_q == TBL_FETCH)
		begin
			w_addr = tdest_q;
			w_data = prog_data_i[DATA_W-1:0];
			w_do   = !tdest_null_q;
		end
		else
		begin
			w_addr = wr_eff;
			w_data = seq_data;
			w_do   = seq_wr && !wr_null;
		end
	end

	// Table read sequencer: request cycle, then fetch-and-load cycle
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			state_q <= TBL_IDLE;
		else
			case (state_q)
				TBL_IDLE:  state_q <= tbl_take ? TBL_FETCH : TBL_IDLE;
				TBL_FETCH: state_q <= TBL_IDLE;
				default:   state_q <= TBL_IDLE;
			endcase
	end

	// Capture program address and resolved target when a read starts
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			paddr_q      <= LAST_PAGE_BASE;
			tdest_q      <= RESET_BYTE;
			tdest_null_q <= 1'b0;
		end
		else if (tbl_take)
		begin
			paddr_q      <= paddr_d;
			tdest_q      <= td_eff;
			tdest_null_q <= td_null;
		end
	end

	// Completion pulse in the cycle after the load
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			done_q <= 1'b0;
		else
			done_q <= (state_q == TBL_FETCH);
	end

	// High byte only loads from a table word; program writes never reach it
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			tbl_high_q <= RESET_BYTE;
		else if (state_q == TBL_FETCH)
			tbl_high_q <= {1'b0, prog_data_i[PWORD_W-1:DATA_W]};
	end

	// Memory pointer: full eight bits so it reaches the special area too
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			ptr_q <= RESET_BYTE;
		else if (w_do && (w_addr == ADDR_PTR))
			ptr_q <= w_data;
	end

	// Table pointers are plain registers
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
		begin
			tbl_low_q   <= RESET_BYTE;
			tbl_upper_q <= RESET_BYTE;
		end
		else
		begin
			if (w_do && (w_addr == ADDR_TBL_LOW))
				tbl_low_q <= w_data;
			if (w_do && (w_addr == ADDR_TBL_UPPER))
				tbl_upper_q <= w_data;
		end
	end

	// Accumulator: ALU load wins over a memory-mapped write in the same cycle
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			acc_q <= RESET_BYTE;
		else if (acc_load_i)
			acc_q <= alu_data_i;
		else if (w_do && (w_addr == ADDR_ACC))
			acc_q <= w_data;
	end

	// General purpose RAM; no reset, contents undefined until written
	always_ff @(posedge mclk_i)
	begin
		if (w_do && in_gp(w_addr))
			mem_q[GP_IDX_W'(w_addr - GP_BASE)] <= w_data;
	end

	// Registered read port
	always_ff @(posedge mclk_i)
	begin
		if (rst_i)
			rd_data_q <= ZERO_BYTE;
		else if (rd_en_i)
			rd_data_q <= rd_null ? ZERO_BYTE : read_loc(rd_eff);
	end

	assign rd_data_o   = rd_data_q;
	assign acc_o       = acc_q;
	assign prog_addr_o = paddr_q;
	assign tbl_busy_o  = (state_q == TBL_FETCH);
	assign tbl_done_o  = done_q;

	// Checks on the table path and the data map
	tbl_two_cycle_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		tbl_req_i && !tbl_busy_o |=> tbl_busy_o ##1 (!tbl_busy_o && tbl_done_o))
		else $error("table read did not finish in two cycles");

	last_page_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		tbl_take && tbl_last_page_i |=>
		prog_addr_o == (LAST_PAGE_BASE + {{PAGE_W{1'b0}}, $past(tbl_low_q)}))
		else $error("last page table address wrong");

	cur_page_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		tbl_take && !tbl_last_page_i && !upper_en_i |=>
		prog_addr_o == {$past(pc_i[PADDR_W-1:DATA_W]), $past(tbl_low_q)})
		else $error("current page table address wrong");

	upper_page_addr_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		tbl_take && !tbl_last_page_i && upper_en_i |=>
		prog_addr_o == {$past(tbl_upper_q[PAGE_W-1:0]), $past(tbl_low_q)})
		else $error("upper pointer page not used");

	high_byte_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		state_q == TBL_FETCH |=> tbl_high_q == {1'b0, $past(prog_data_i[PWORD_W-1:DATA_W])})
		else $error("high byte not loaded from table word");

	high_byte_ro_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_wr && (wr_eff == ADDR_TBL_HIGH) |=> $stable(tbl_high_q))
		else $error("high byte register changed by a write");

	null_read_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_en_i && rd_null |=> rd_data_o == ZERO_BYTE)
		else $error("indirect self read not zero");

	hole_read_zero_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		rd_en_i && !in_gp(rd_eff) && (rd_eff != ADDR_PTR)
		&& (rd_eff != ADDR_ACC) && (rd_eff != ADDR_TBL_LOW) && (rd_eff != ADDR_TBL_HIGH)
		&& (rd_eff != ADDR_TBL_UPPER) |=> rd_data_o == ZERO_BYTE)
		else $error("unused location not read as zero");

	acc_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		acc_load_i |=> acc_o == $past(alu_data_i))
		else $error("accumulator missed ALU result");

	ptr_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
		seq_wr && !wr_null && (wr_eff == ADDR_PTR) && (bit_op_i == BOP_NONE)
		&& (wr_src_i == SRC_ALU) |=> ptr_q == $past(alu_data_i))
		else $error("pointer write lost");

	last_page_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		tbl_take && tbl_last_page_i ##2 tbl_done_o);
	indirect_wr_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		seq_wr && (wr_addr_i == ADDR_IND) && in_gp(wr_eff));
	null_rd_c: cover property (@(posedge mclk_i) disable iff (rst_i)
		rd_en_i && rd_null);

endmodule

// *** verification/prog_rom_model.sv ***
// Program memory model that answers table fetches in the same cycle.
// Assumes the fetch address stands through the busy cycle.
`timescale 1ns/1ns
module prog_rom_model
	import dmem_pkg::*;
(
	input  wire logic [PADDR_W-1:0] addr_i,
	input  wire logic               busy_i,
	output logic      [PWORD_W-1:0] data_o
);
	// Word is a scramble of its address; off the fetch cycle the bus carries junk
	always_comb
	begin
		data_o = {addr_i[10:4], addr_i[7:0]} ^ 15'h2d5a;
		if (!busy_i)
			data_o = ~data_o;
	end
endmodule

// *** verification/data_memory_table_access_tb.sv ***
// Self-checking bench for the data memory, indirect port and table reads.
// Assumes a 250 MHz core clock and the program memory model on the fetch port.
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module data_memory_table_access_tb
	import dmem_pkg::*;
;
	logic                mclk_i = 0;
	logic                rst_i = 1;
	logic                rd_en_i = 0;
	logic                wr_en_i = 0;
	logic                wr_src_i = 0;
	logic                acc_load_i = 0;
	logic                tbl_req_i = 0;
	logic                tbl_last_page_i = 0;
	logic                upper_en_i = 0;
	logic [7:0]          rd_addr_i = 0;
	logic [7:0]          wr_addr_i = 0;
	logic [7:0]          alu_data_i = 0;
	logic [7:0]          tbl_dest_i = 0;
	logic [1:0]          bit_op_i = 0;
	logic [2:0]          bit_sel_i = 0;
	logic [PADDR_W-1:0]  pc_i = 0;
	logic [7:0]          rd_data_o;
	logic [7:0]          acc_o;
	logic                tbl_busy_o;
	logic                tbl_done_o;
	logic [PADDR_W-1:0]  prog_addr_o;
	logic [PWORD_W-1:0]  prog_data_i;
	logic [7:0]          a;
	logic [7:0]          d;
	logic [7:0]          p;
	int                  errors = 0;
	int                  total_checks = 0;
	int                  seed = 61;

	// Clock at 4 ns period
	always #2 mclk_i = ~mclk_i;

	data_memory_table_access dut_u (.mclk_i, .rst_i, .rd_en_i, .rd_addr_i, .rd_data_o,
		.wr_en_i, .wr_addr_i, .wr_src_i, .bit_op_i, .bit_sel_i, .alu_data_i, .acc_load_i,
		.acc_o, .tbl_req_i, .tbl_last_page_i, .tbl_dest_i, .pc_i, .upper_en_i, .tbl_busy_o,
		.tbl_done_o, .prog_addr_o, .prog_data_i);

	prog_rom_model rom_u (.addr_i(prog_addr_o), .busy_i(tbl_busy_o), .data_o(prog_data_i));

	// One write cycle; op 11 writes the accumulator instead of the ALU value
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt, input logic [1:0] op);
		@(negedge mclk_i);
		wr_en_i = 1;
		wr_addr_i = ad;
		alu_data_i = dt;
		bit_sel_i = dt[2:0];
		bit_op_i = (op == 2'b11) ? 2'b00 : op;
		wr_src_i = (op != 2'b11);
		@(negedge mclk_i);
		wr_en_i = 0;
		bit_op_i = 0;
	endtask

	// One read cycle, data compared one cycle later
	task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
		@(negedge mclk_i);
		rd_en_i = 1;
		rd_addr_i = ad;
		@(negedge mclk_i);
		rd_en_i = 0;
		`CHK("rd_data_o", ex, rd_data_o)
	endtask

	// Table address from the page rules: last page base, running page or upper pointer
	function automatic logic [PADDR_W-1:0] exp_addr(input logic last, input logic up);
		exp_addr = last ? LAST_PAGE_BASE + 11'(p) : {(up ? d[2:0] : pc_i[10:8]), p};
	endfunction

	// Word that the program memory model holds at a fetch address
	function automatic logic [PWORD_W-1:0] exp_word(input logic [PADDR_W-1:0] ad);
		exp_word = {ad[10:4], ad[7:0]} ^ 15'h2d5a;
	endfunction

	// Table read into dst using pointer p, upper pointer d and pc_i
	task automatic tb(input logic last, input logic up, input logic [7:0] dst);
		logic [14:0] w;
		logic [10:0] ex;
		ex = exp_addr(last, up);
		w = exp_word(ex);
		@(negedge mclk_i);
		tbl_req_i = 1;
		tbl_last_page_i = last;
		upper_en_i = up;
		tbl_dest_i = dst;
		@(negedge mclk_i);
		tbl_req_i = 0;
		`CHK("tbl_busy_o", 1'b1, tbl_busy_o)
		`CHK("prog_addr_o", ex, prog_addr_o)
		@(negedge mclk_i);
		`CHK("tbl_done_o", 1'b1, tbl_done_o)
		`CHK("tbl_busy_o", 1'b0, tbl_busy_o)
		rd(dst, w[7:0]);
		rd(ADDR_TBL_HIGH, {1'b0, w[14:8]});
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Cuts a hang short
	initial
	begin
		#100000;
		errors++;
		end_sim();
	end

	// Main sequence
	initial
	begin
		repeat (10) @(negedge mclk_i);
		rst_i = 0;
		`CHK("acc_o", 8'h00, acc_o)
		`CHK("prog_addr_o", LAST_PAGE_BASE, prog_addr_o)
		wr(ADDR_TBL_HIGH, 8'h55, BOP_NONE);
		rd(ADDR_TBL_HIGH, 8'h00);
		wr(8'h02, 8'hff, BOP_SET);
		rd(8'h02, 8'h00);
		$display("test special area done");
		// Random general locations, with bit set and clear on each
		for (int i = 0; i < 20; i++)
		begin
			a = (i == 0) ? GP_LAST : GP_BASE + 8'($unsigned($random(seed)) % GP_DEPTH);
			d = 8'($random(seed));
			p = 8'($random(seed)) & 8'h07;
			wr(a, d, BOP_NONE);
			rd(a, d);
			wr(a, p, BOP_SET);
			rd(a, d | (8'h01 << p));
			wr(a, p, BOP_CLR);
			rd(a, d & ~(8'h01 << p));
		end
		$display("test general memory done");
		wr(ADDR_PTR, GP_LAST, BOP_NONE);
		rd(ADDR_PTR, GP_LAST);
		wr(ADDR_IND, 8'h3c, BOP_NONE);
		rd(GP_LAST, 8'h3c);
		rd(ADDR_IND, 8'h3c);
		wr(ADDR_PTR, ADDR_IND, BOP_NONE);
		wr(ADDR_IND, 8'h77, BOP_NONE);
		rd(ADDR_IND, 8'h00);
		rd(GP_LAST, 8'h3c);
		$display("test indirect port done");
		d = 8'($random(seed));
		@(negedge mclk_i);
		acc_load_i = 1;
		alu_data_i = d;
		@(negedge mclk_i);
		acc_load_i = 0;
		`CHK("acc_o", d, acc_o)
		wr(GP_BASE, 8'h00, 2'b11);
		rd(GP_BASE, d);
		$display("test accumulator done");
		// Table reads from one context only, so the high byte is never clobbered
		for (int i = 0; i < 8; i++)
		begin
			p = (i == 0) ? 8'hff : 8'($random(seed));
			d = 8'($random(seed));
			a = GP_BASE + 8'($unsigned($random(seed)) % GP_DEPTH);
			pc_i = 11'($random(seed));
			wr(ADDR_TBL_LOW, p, BOP_NONE);
			wr(ADDR_TBL_UPPER, d, BOP_NONE);
			tb(1'b1, 1'b0, a);
			tb(1'b0, 1'b0, a);
			tb(1'b0, 1'b1, a);
		end
		$display("test table reads done");
		end_sim();
	end
endmodule
